// [hw/rkp_pkg.sv]
// Purpose: Shared constants, types and decode functions for the keyed indirect access port.
// Assumes: Eight-bit special-function register bus, one system clock.
// Notes: Host command register offsets and operation codes are also kept here, shared by the controller end and the bench.
package rkp_pkg;
	localparam logic [7:0] RKP_ADR_OFS = 8'hAC;
	localparam logic [7:0] RKP_DAT_OFS = 8'hAD;
	localparam logic [7:0] RKP_KEY_OFS = 8'hAE;

	localparam logic [7:0] RKP_KEY_FIRST = 8'hA5;
	localparam logic [7:0] RKP_KEY_SECOND = 8'hF1;

	localparam logic [7:0] RKP_CODE_LOCKED = 8'h00;
	localparam logic [7:0] RKP_CODE_WAIT2 = 8'h01;
	localparam logic [7:0] RKP_CODE_UNLOCKED = 8'h02;
	localparam logic [7:0] RKP_CODE_DISABLED = 8'h03;

	localparam int RKP_BUSY_BIT = 7;
	localparam int RKP_AUTO_BIT = 6;
	localparam int RKP_VREG_BIT = 5;
	localparam int RKP_SHORT_BIT = 4;

	localparam logic [3:0] RKP_SEL_CAP_LAST = 4'h5;
	localparam logic [3:0] RKP_SEL_CTRL = 4'h6;
	localparam logic [3:0] RKP_SEL_OSC = 4'h7;
	localparam logic [3:0] RKP_SEL_ALM_FIRST = 4'h8;
	localparam logic [3:0] RKP_SEL_ALM_LAST = 4'hD;
	localparam logic [3:0] RKP_SEL_RAMIDX = 4'hE;
	localparam logic [3:0] RKP_SEL_RAMDAT = 4'hF;
	localparam logic [3:0] RKP_SEL_STEP = 4'h1;

	localparam int RKP_GROUP_BYTES = 6;
	localparam int RKP_RAM_DEPTH = 64;

	localparam logic [2:0] RKP_STROBE_LONG = 3'h4;
	localparam logic [2:0] RKP_STROBE_SHORT = 3'h1;
	localparam logic [2:0] RKP_CNT_STEP = 3'h1;

	localparam logic [7:0] RKP_CTRL_RST = 8'h00;
	localparam logic [7:0] RKP_OSC_RST = 8'h00;
	localparam logic [7:0] RKP_BYTE_RST = 8'h00;

	localparam logic [2:0] RKP_H_CMD_OFS = 3'h0;
	localparam logic [2:0] RKP_H_CFG_OFS = 3'h1;
	localparam logic [2:0] RKP_H_WDATA_OFS = 3'h2;
	localparam logic [2:0] RKP_H_RES_OFS = 3'h3;
	localparam logic [2:0] RKP_H_STAT_OFS = 3'h4;

	localparam logic [1:0] RKP_OP_STATUS = 2'h0;
	localparam logic [1:0] RKP_OP_UNLOCK = 2'h1;
	localparam logic [1:0] RKP_OP_WRITE = 2'h2;
	localparam logic [1:0] RKP_OP_READ = 2'h3;

	typedef enum logic [1:0] {LK_LOCKED, LK_WAIT2, LK_UNLOCKED, LK_DISABLED} rkp_lock_e;

	typedef enum logic [3:0] {H_IDLE, H_KEY1, H_KEY2, H_POLL, H_POLLW, H_POLLCHK, H_SETADR, H_WRDAT,
		H_RD, H_RDW, H_RDCAP} rkp_hstate_e;

	function automatic logic rkp_is_cap(input logic [3:0] sel);
		return sel <= RKP_SEL_CAP_LAST;
	endfunction : rkp_is_cap

	function automatic logic rkp_is_alm(input logic [3:0] sel);
		return (sel >= RKP_SEL_ALM_FIRST) && (sel <= RKP_SEL_ALM_LAST);
	endfunction : rkp_is_alm

	function automatic logic [7:0] rkp_lock_code(input rkp_lock_e s);
		case (s)
			LK_LOCKED: return RKP_CODE_LOCKED;
			LK_WAIT2: return RKP_CODE_WAIT2;
			LK_UNLOCKED: return RKP_CODE_UNLOCKED;
			default: return RKP_CODE_DISABLED;
		endcase
	endfunction : rkp_lock_code
endpackage : rkp_pkg

// [hw/rkp_sfr_if.sv]
// Purpose: Special-function register bus between the processor-side controller and the access port.
// Assumes: One clock shared by both ends; read data stand in the cycle after the read strobe.
// Notes: Strobes are one cycle long and never both high at once.
`timescale 1ns/1ps
interface rkp_sfr_if;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;

	modport device (
		input addr,
		input wdata,
		input wr,
		input rd,
		output rdata
	);

	modport host (
		output addr,
		output wdata,
		output wr,
		output rd,
		input rdata
	);
endinterface : rkp_sfr_if

// [hw/rkp_device.sv]
// Purpose: Keyed indirect access port and the internal register bank behind it.
// Assumes: Synchronous active-low reset; backupAboveCore arrives from the supply comparator, unsynchronised.
// Notes: Address register control fields, the data register and the battery-backed bytes carry no reset; the busy bit resets.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
module rkp_device
	import rkp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	rkp_sfr_if.device sfr,
	input wire logic backupAboveCore,
	output logic [7:0] rtcCtrl,
	output logic [7:0] oscCtrl,
	output logic portBusy
);

	rkp_lock_e lockState_r;
	rkp_lock_e lockState_nxt;
	logic busy_r;
	logic opWrite_r;
	logic [2:0] cnt_r;
	logic auto_read_enable_r;
	logic vreg_r;
	logic short_r;
	logic [3:0] sel_r;
	logic [7:0] dat_r;
	logic [7:0] cap_r [0:RKP_GROUP_BYTES-1];
	logic [7:0] alm_r [0:RKP_GROUP_BYTES-1];
	logic [7:0] ctrl_r;
	logic [7:0] osc_r;
	logic [5:0] ramIdx_r;
	logic [7:0] ram_r [0:RKP_RAM_DEPTH-1];
	logic [1:0] vSync_r;
	logic [7:0] rdata_r;
	logic [7:0] intRd;
	logic [7:0] sfrRd;
	logic [7:0] wrByte;
	logic wrKey;
	logic wrAdr;
	logic wrDat;
	logic rdAdr;
	logic rdDat;
	logic unlocked;
	logic invalid;
	logic adrTake;
	logic startRd;
	logic startWr;
	logic opDone;
	logic shortEff;

	assign wrKey = sfr.wr && (sfr.addr == RKP_KEY_OFS);
	assign wrAdr = sfr.wr && (sfr.addr == RKP_ADR_OFS);
	assign wrDat = sfr.wr && (sfr.addr == RKP_DAT_OFS);
	assign rdAdr = sfr.rd && (sfr.addr == RKP_ADR_OFS);
	assign rdDat = sfr.rd && (sfr.addr == RKP_DAT_OFS);
	assign unlocked = (lockState_r == LK_UNLOCKED);
	assign invalid = (wrAdr || wrDat || rdAdr || rdDat) && !unlocked;

	// Address register writes are ignored while an access runs so the target cannot move under it.
	assign adrTake = wrAdr && unlocked && !busy_r;
	assign startRd = unlocked && !busy_r && ((wrAdr && sfr.wdata[RKP_BUSY_BIT]) || (rdDat && auto_read_enable_r));
	assign startWr = unlocked && !busy_r && wrDat;
	assign opDone = busy_r && (cnt_r == RKP_STROBE_SHORT);
	assign shortEff = wrAdr ? sfr.wdata[RKP_SHORT_BIT] : short_r;

	always_comb begin
		lockState_nxt = lockState_r;
		if (invalid) begin
			lockState_nxt = LK_DISABLED;
		end else if (wrKey) begin
			case (lockState_r)
				LK_LOCKED: begin
					lockState_nxt = (sfr.wdata == RKP_KEY_FIRST) ? LK_WAIT2 : LK_DISABLED;
				end
				LK_WAIT2: begin
					lockState_nxt = (sfr.wdata == RKP_KEY_SECOND) ? LK_UNLOCKED : LK_DISABLED;
				end
				LK_UNLOCKED: begin
					lockState_nxt = LK_LOCKED;
				end
				LK_DISABLED: begin
					lockState_nxt = LK_DISABLED;
				end
				default: begin
					lockState_nxt = LK_DISABLED;
				end
			endcase
		end
	end

	// Reads of the key register never enter the state update.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lockState_r <= LK_LOCKED;
		end else begin
			lockState_r <= lockState_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			opWrite_r <= 1'b0;
			cnt_r <= RKP_STROBE_SHORT;
		end else if (startRd || startWr) begin
			busy_r <= 1'b1;
			opWrite_r <= startWr;
			cnt_r <= shortEff ? RKP_STROBE_SHORT : RKP_STROBE_LONG;
		end else if (opDone) begin
			busy_r <= 1'b0;
		end else if (busy_r) begin
			cnt_r <= cnt_r - RKP_CNT_STEP;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			vSync_r <= 2'b00;
		end else begin
			vSync_r <= {vSync_r[0], backupAboveCore};
		end
	end

	// Control fields of the address register have no reset and keep their value across it.
	always_ff @(posedge mclk) begin
		if (adrTake) begin
			auto_read_enable_r <= sfr.wdata[RKP_AUTO_BIT];
			short_r <= sfr.wdata[RKP_SHORT_BIT];
			sel_r <= sfr.wdata[3:0];
		end else if (opDone && (rkp_is_cap(sel_r) || rkp_is_alm(sel_r))) begin
			sel_r <= sel_r + RKP_SEL_STEP;
		end
	end

	// The supply comparator wins over a software clear in the same cycle.
	always_ff @(posedge mclk) begin
		if (vSync_r[1]) begin
			vreg_r <= 1'b1;
		end else if (adrTake) begin
			vreg_r <= sfr.wdata[RKP_VREG_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (startWr) begin
			dat_r <= sfr.wdata;
		end else if (opDone && !opWrite_r) begin
			dat_r <= intRd;
		end
	end

	// Byte zero of each 47-bit group never stores its lowest bit.
	always_comb begin
		wrByte = dat_r;
		if ((rkp_is_cap(sel_r) || rkp_is_alm(sel_r)) && (sel_r[2:0] == 3'h0)) begin
			wrByte[0] = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (opDone && opWrite_r) begin
			if (rkp_is_cap(sel_r)) begin
				cap_r[sel_r[2:0]] <= wrByte;
			end else if (rkp_is_alm(sel_r)) begin
				alm_r[sel_r[2:0]] <= wrByte;
			end else if (sel_r == RKP_SEL_RAMIDX) begin
				ramIdx_r <= dat_r[5:0];
			end else if (sel_r == RKP_SEL_RAMDAT) begin
				ram_r[ramIdx_r] <= dat_r;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_r <= RKP_CTRL_RST;
			osc_r <= RKP_OSC_RST;
		end else if (opDone && opWrite_r) begin
			if (sel_r == RKP_SEL_CTRL) begin
				ctrl_r <= dat_r;
			end
			if (sel_r == RKP_SEL_OSC) begin
				osc_r <= dat_r;
			end
		end
	end

	always_comb begin
		intRd = RKP_BYTE_RST;
		if (rkp_is_cap(sel_r)) begin
			intRd = cap_r[sel_r[2:0]];
		end else if (rkp_is_alm(sel_r)) begin
			intRd = alm_r[sel_r[2:0]];
		end else begin
			case (sel_r)
				RKP_SEL_CTRL: intRd = ctrl_r;
				RKP_SEL_OSC: intRd = osc_r;
				RKP_SEL_RAMIDX: intRd = {2'b00, ramIdx_r};
				RKP_SEL_RAMDAT: intRd = ram_r[ramIdx_r];
				default: intRd = RKP_BYTE_RST;
			endcase
		end
	end

	always_comb begin
		sfrRd = RKP_BYTE_RST;
		if (sfr.addr == RKP_KEY_OFS) begin
			sfrRd = rkp_lock_code(lockState_r);
		end else if ((sfr.addr == RKP_ADR_OFS) && unlocked) begin
			sfrRd = {busy_r, auto_read_enable_r, vreg_r, short_r, sel_r};
		end else if ((sfr.addr == RKP_DAT_OFS) && unlocked) begin
			sfrRd = dat_r;
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_r <= RKP_BYTE_RST;
		end else if (sfr.rd) begin
			rdata_r <= sfrRd;
		end else begin
			rdata_r <= RKP_BYTE_RST;
		end
	end

	assign sfr.rdata = rdata_r;
	assign rtcCtrl = ctrl_r;
	assign oscCtrl = osc_r;
	assign portBusy = busy_r;

endmodule : rkp_device

// [hw/rkp_host.sv]
// Purpose: Processor-side controller that drives the keyed indirect access port on command.
// Assumes: Commands arrive on a plain register port; read data stand one cycle after the read strobe.
// Notes: One command runs at a time; commands written while busy are dropped.
`timescale 1ns/1ps
module rkp_host
	import rkp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	rkp_sfr_if.host sfr,
	input wire logic [2:0] cmdAddr,
	input wire logic [7:0] cmdWdata,
	input wire logic cmdWr,
	input wire logic cmdRd,
	output logic [7:0] cmdRdata
);

	rkp_hstate_e hstate_r;
	logic [1:0] op_r;
	logic phase_r;
	logic [7:0] cfg_r;
	logic [7:0] wbyte_r;
	logic [7:0] res_r;
	logic [7:0] busAddr_r;
	logic [7:0] busWdata_r;
	logic busWr_r;
	logic busRd_r;
	logic [7:0] cmdRdata_r;
	logic cmdGo;

	assign cmdGo = cmdWr && (cmdAddr == RKP_H_CMD_OFS) && (hstate_r == H_IDLE);

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg_r <= RKP_BYTE_RST;
			wbyte_r <= RKP_BYTE_RST;
		end else if (cmdWr) begin
			if (cmdAddr == RKP_H_CFG_OFS) begin
				cfg_r <= cmdWdata;
			end
			if (cmdAddr == RKP_H_WDATA_OFS) begin
				wbyte_r <= cmdWdata;
			end
		end
	end

	// Sequencer and bus strobes share one process so every strobe lasts exactly one cycle.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			hstate_r <= H_IDLE;
			op_r <= RKP_OP_STATUS;
			phase_r <= 1'b0;
			res_r <= RKP_BYTE_RST;
			busAddr_r <= RKP_BYTE_RST;
			busWdata_r <= RKP_BYTE_RST;
			busWr_r <= 1'b0;
			busRd_r <= 1'b0;
		end else begin
			busWr_r <= 1'b0;
			busRd_r <= 1'b0;
			case (hstate_r)
				H_IDLE: begin
					if (cmdGo) begin
						op_r <= cmdWdata[1:0];
						phase_r <= 1'b0;
						case (cmdWdata[1:0])
							RKP_OP_UNLOCK: hstate_r <= H_KEY1;
							RKP_OP_STATUS: hstate_r <= H_RD;
							default: hstate_r <= H_POLL;
						endcase
					end
				end
				H_KEY1: begin
					busWr_r <= 1'b1;
					busAddr_r <= RKP_KEY_OFS;
					busWdata_r <= RKP_KEY_FIRST;
					hstate_r <= H_KEY2;
				end
				H_KEY2: begin
					busWr_r <= 1'b1;
					busAddr_r <= RKP_KEY_OFS;
					busWdata_r <= RKP_KEY_SECOND;
					hstate_r <= H_IDLE;
				end
				H_POLL: begin
					busRd_r <= 1'b1;
					busAddr_r <= RKP_ADR_OFS;
					hstate_r <= H_POLLW;
				end
				H_POLLW: begin
					hstate_r <= H_POLLCHK;
				end
				H_POLLCHK: begin
					if (sfr.rdata[RKP_BUSY_BIT]) begin
						hstate_r <= H_POLL;
					end else if (!phase_r) begin
						hstate_r <= H_SETADR;
					end else begin
						hstate_r <= H_RD;
					end
				end
				H_SETADR: begin
					busWr_r <= 1'b1;
					busAddr_r <= RKP_ADR_OFS;
					busWdata_r <= {(op_r == RKP_OP_READ), cfg_r[6:0]};
					if (op_r == RKP_OP_WRITE) begin
						hstate_r <= H_WRDAT;
					end else begin
						phase_r <= 1'b1;
						hstate_r <= H_POLL;
					end
				end
				H_WRDAT: begin
					busWr_r <= 1'b1;
					busAddr_r <= RKP_DAT_OFS;
					busWdata_r <= wbyte_r;
					hstate_r <= H_IDLE;
				end
				H_RD: begin
					busRd_r <= 1'b1;
					busAddr_r <= (op_r == RKP_OP_STATUS) ? RKP_KEY_OFS : RKP_DAT_OFS;
					hstate_r <= H_RDW;
				end
				H_RDW: begin
					hstate_r <= H_RDCAP;
				end
				H_RDCAP: begin
					res_r <= sfr.rdata;
					hstate_r <= H_IDLE;
				end
				default: begin
					hstate_r <= H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cmdRdata_r <= RKP_BYTE_RST;
		end else if (cmdRd) begin
			case (cmdAddr)
				RKP_H_CMD_OFS: cmdRdata_r <= {6'h00, op_r};
				RKP_H_CFG_OFS: cmdRdata_r <= cfg_r;
				RKP_H_WDATA_OFS: cmdRdata_r <= wbyte_r;
				RKP_H_RES_OFS: cmdRdata_r <= res_r;
				RKP_H_STAT_OFS: cmdRdata_r <= {7'h00, (hstate_r != H_IDLE)};
				default: cmdRdata_r <= RKP_BYTE_RST;
			endcase
		end else begin
			cmdRdata_r <= RKP_BYTE_RST;
		end
	end

	assign sfr.addr = busAddr_r;
	assign sfr.wdata = busWdata_r;
	assign sfr.wr = busWr_r;
	assign sfr.rd = busRd_r;
	assign cmdRdata = cmdRdata_r;

endmodule : rkp_host

// [verification/rkp_properties.sv]
// Purpose: Assertions on the register bus between the host controller and the access port.
// Assumes: One clock; the bus signals are watched as plain inputs.
// Notes: Helper logic tracks lock state, busy time and address fields from bus traffic alone.
`timescale 1ns/1ps
module rkp_properties
	import rkp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata,
	input wire logic backupAboveCore
);
	logic [7:0] lockCode_r;
	logic [2:0] busyCnt_r;
	logic [3:0] sel_r;
	logic auto_r;
	logic short_r;
	logic fieldsOk_r = 1'b0;
	logic open;
	logic grp;
	assign open = lockCode_r == RKP_CODE_UNLOCKED;
	assign grp = sel_r <= RKP_SEL_CAP_LAST || (sel_r >= RKP_SEL_ALM_FIRST && sel_r <= RKP_SEL_ALM_LAST);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			lockCode_r <= RKP_CODE_LOCKED;
		end else if ((wr || rd) && (addr == RKP_ADR_OFS || addr == RKP_DAT_OFS) && !open) begin
			lockCode_r <= RKP_CODE_DISABLED;
		end else if (wr && addr == RKP_KEY_OFS) begin
			case (lockCode_r)
				RKP_CODE_LOCKED: lockCode_r <= (wdata == RKP_KEY_FIRST) ? RKP_CODE_WAIT2 : RKP_CODE_DISABLED;
				RKP_CODE_WAIT2: lockCode_r <= (wdata == RKP_KEY_SECOND) ? RKP_CODE_UNLOCKED : RKP_CODE_DISABLED;
				RKP_CODE_UNLOCKED: lockCode_r <= RKP_CODE_LOCKED;
				default: lockCode_r <= lockCode_r;
			endcase
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			busyCnt_r <= 3'h0;
		end else if (busyCnt_r != 3'h0) begin
			busyCnt_r <= busyCnt_r - RKP_CNT_STEP;
		end else if (open && wr && addr == RKP_ADR_OFS && wdata[RKP_BUSY_BIT]) begin
			busyCnt_r <= wdata[RKP_SHORT_BIT] ? RKP_STROBE_SHORT : RKP_STROBE_LONG;
		end else if (open && addr == RKP_DAT_OFS && (wr || (rd && auto_r))) begin
			busyCnt_r <= short_r ? RKP_STROBE_SHORT : RKP_STROBE_LONG;
		end
	end
	// Address fields carry no reset, so they are only compared once written.
	always_ff @(posedge mclk) begin
		if (open && wr && addr == RKP_ADR_OFS && busyCnt_r == 3'h0) begin
			sel_r <= wdata[3:0];
			auto_r <= wdata[RKP_AUTO_BIT];
			short_r <= wdata[RKP_SHORT_BIT];
			fieldsOk_r <= 1'b1;
		end else if (rst_n && busyCnt_r == 3'h1 && grp) begin
			sel_r <= sel_r + RKP_SEL_STEP;
		end
	end
	key_code_a: assert property (rd && addr == RKP_KEY_OFS |=> rdata == $past(lockCode_r))
		else $error("lock state code differs from the key sequence");
	locked_block_a: assert property (rd && !open && (addr == RKP_ADR_OFS || addr == RKP_DAT_OFS) |=> rdata == 8'h00)
		else $error("blocked register read returned data");
	busy_bit_a: assert property (rd && open && addr == RKP_ADR_OFS |=> rdata[7] == ($past(busyCnt_r) != 3'h0))
		else $error("busy bit does not match the access length");
	sel_track_a: assert property (rd && open && addr == RKP_ADR_OFS && busyCnt_r == 3'h0 && fieldsOk_r
		|=> rdata[3:0] == $past(sel_r) && rdata[6] == $past(auto_r) && rdata[4] == $past(short_r))
		else $error("address fields wrong after an access");
	key_pair_a: assert property (wr && addr == RKP_KEY_OFS && wdata == RKP_KEY_FIRST
		|=> wr && addr == RKP_KEY_OFS && wdata == RKP_KEY_SECOND)
		else $error("second key did not follow the first");
	poll_busy_a: assert property (open && wr && (addr == RKP_DAT_OFS || (addr == RKP_ADR_OFS && wdata[7]))
		|-> busyCnt_r == 3'h0)
		else $error("access started while busy");
	auto_poll_a: assert property (open && rd && addr == RKP_DAT_OFS |-> busyCnt_r == 3'h0)
		else $error("data read while busy");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
		else $error("read data outside an answer cycle");
	// The supply level needs two synchroniser stages and one update edge before the address register shows it.
	vreg_force_a: assert property (rd && open && addr == RKP_ADR_OFS && $past(backupAboveCore, 3)
		|=> rdata[RKP_VREG_BIT])
		else $error("regulator enable not forced by the backup supply");
	cover property (open);
	cover property (lockCode_r == RKP_CODE_DISABLED);
	cover property (open && rd && addr == RKP_DAT_OFS && auto_r);
	cover property (open && wr && addr == RKP_ADR_OFS && wdata[7] && wdata[4]);
endmodule : rkp_properties

// [verification/rtc_keyed_indirect_access_port_test.sv]
// Purpose: Self-checking bench for the host controller and access port joined back to back.
// Assumes: Host command offsets and op codes from the shared package.
// Notes: Write and read-back cases run from a table; lock and reset cases follow by hand.
`timescale 1ns/1ps
module rtc_keyed_indirect_access_port_test
	import rkp_pkg::*;
;
	typedef struct packed {logic [7:0] cfg; logic [7:0] data; logic [7:0] exp;} rkp_row_s;
	localparam rkp_row_s ROWS [9] = '{
		'{8'h06, 8'hA5, 8'hA5}, '{8'h17, 8'h3C, 8'h3C},
		'{8'h00, 8'hFF, 8'hFE}, '{8'h18, 8'h81, 8'h80},
		'{8'h05, 8'h5A, 8'h5A}, '{8'h1D, 8'hC3, 8'hC3},
		'{8'h0E, 8'h6A, 8'h2A}, '{8'h1F, 8'h77, 8'h77},
		'{8'h41, 8'h96, 8'h96}
	};
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] cmdAddr = 3'h0;
	logic [7:0] cmdWdata = 8'h00;
	logic cmdWr = 1'b0;
	logic cmdRd = 1'b0;
	logic backupAboveCore = 1'b0;
	logic [7:0] cmdRdata;
	logic [7:0] rtcCtrl;
	logic [7:0] oscCtrl;
	logic portBusy;
	int numErrors = 0;
	int checkCount = 0;
	int cycles = 0;
	rkp_sfr_if sfrBus();
	rkp_host i_rkp_host(.mclk(mclk), .rst_n(rst_n), .sfr(sfrBus.host), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
		.cmdWr(cmdWr), .cmdRd(cmdRd), .cmdRdata(cmdRdata));
	rkp_device i_rkp_device(.mclk(mclk), .rst_n(rst_n), .sfr(sfrBus.device), .backupAboveCore(backupAboveCore),
		.rtcCtrl(rtcCtrl), .oscCtrl(oscCtrl), .portBusy(portBusy));
	rkp_properties i_rkp_properties(.mclk(mclk), .rst_n(rst_n), .addr(sfrBus.addr), .wdata(sfrBus.wdata),
		.wr(sfrBus.wr), .rd(sfrBus.rd), .rdata(sfrBus.rdata), .backupAboveCore(backupAboveCore));
	always #5 mclk = ~mclk;
	task automatic stopTest();
		$display("checks %0d, mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : stopTest
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			stopTest();
		end
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checkCount++;
		if (seen !== exp) begin
			numErrors++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic cmdWrite(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		cmdAddr <= a;
		cmdWdata <= d;
		cmdWr <= 1'b1;
		@(posedge mclk);
		cmdWr <= 1'b0;
	endtask : cmdWrite
	task automatic cmdRead(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		cmdAddr <= a;
		cmdRd <= 1'b1;
		@(posedge mclk);
		cmdRd <= 1'b0;
		#1;
		d = cmdRdata;
	endtask : cmdRead
	task automatic runOp(input logic [1:0] op);
		logic [7:0] st;
		int n;
		cmdWrite(RKP_H_CMD_OFS, {6'h00, op});
		n = 0;
		do begin
			cmdRead(RKP_H_STAT_OFS, st);
			n++;
		end while (st[0] !== 1'b0 && n < 40);
		check(st, 8'h00);
	endtask : runOp
	task automatic lockIs(input logic [7:0] code);
		logic [7:0] d;
		runOp(RKP_OP_STATUS);
		cmdRead(RKP_H_RES_OFS, d);
		check(d, code);
	endtask : lockIs
	task automatic putByte(input logic [7:0] cfg, input logic [7:0] d);
		cmdWrite(RKP_H_CFG_OFS, cfg);
		cmdWrite(RKP_H_WDATA_OFS, d);
		runOp(RKP_OP_WRITE);
	endtask : putByte
	task automatic getByte(input logic [7:0] cfg, input logic [7:0] exp);
		logic [7:0] d;
		cmdWrite(RKP_H_CFG_OFS, cfg);
		runOp(RKP_OP_READ);
		cmdRead(RKP_H_RES_OFS, d);
		check(d, exp);
	endtask : getByte
	initial begin
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		lockIs(RKP_CODE_LOCKED);
		runOp(RKP_OP_UNLOCK);
		lockIs(RKP_CODE_UNLOCKED);
		lockIs(RKP_CODE_UNLOCKED);
		$display("test unlock done");
		foreach (ROWS[i]) begin
			putByte(ROWS[i].cfg, ROWS[i].data);
			getByte(ROWS[i].cfg, ROWS[i].exp);
		end
		check(rtcCtrl, 8'hA5);
		check(oscCtrl, 8'h3C);
		$display("test table done");
		@(posedge mclk);
		backupAboveCore <= 1'b1;
		putByte(8'h0E, 8'h2B);
		check({7'h00, portBusy}, 8'h01);
		repeat (5) @(posedge mclk);
		#1;
		check({7'h00, portBusy}, 8'h00);
		putByte(8'h1F, 8'h11);
		putByte(8'h0E, 8'h2A);
		getByte(8'h1F, 8'h77);
		putByte(8'h0E, 8'h2B);
		getByte(8'h1F, 8'h11);
		@(posedge mclk);
		backupAboveCore <= 1'b0;
		$display("test backup memory done");
		// The first key relocks the port, so the second lands as a wrong first key.
		runOp(RKP_OP_UNLOCK);
		lockIs(RKP_CODE_DISABLED);
		runOp(RKP_OP_UNLOCK);
		lockIs(RKP_CODE_DISABLED);
		getByte(8'h06, 8'h00);
		$display("test lockout done");
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		check(rtcCtrl, RKP_CTRL_RST);
		lockIs(RKP_CODE_LOCKED);
		putByte(8'h06, 8'h55);
		lockIs(RKP_CODE_DISABLED);
		check(rtcCtrl, RKP_CTRL_RST);
		@(posedge mclk);
		rst_n <= 1'b0;
		repeat (6) @(posedge mclk);
		rst_n <= 1'b1;
		runOp(RKP_OP_UNLOCK);
		lockIs(RKP_CODE_UNLOCKED);
		// Backup memory index and its stored byte kept their values through both resets.
		getByte(8'h1F, 8'h11);
		$display("test reset done");
		stopTest();
	end
endmodule : rtc_keyed_indirect_access_port_test
